/* logic/bfsl_host.sv */
// Host controller for a three-phase bridge driver with built-in protection.
// Gates user phase commands onto the driver inputs, owns the shutdown pin
// and produces the all-low pattern that releases the driver's latches.
// Assumes the fault indicator pin is pulled up externally and sampled here.
`timescale 1ns/10ps
`default_nettype none
module bfsl_host (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// User side
	input  wire logic [5:0] phase_cmd,
	input  wire logic       shutdown_cmd,
	input  wire logic       clear_req,
	input  wire logic       ctrl_supply_ok,
	output logic            drive_active,
	output logic            fault_seen,
	// Driver pins
	input  wire logic       fault_indicator_n,
	output logic [5:0]      phase_drive,
	output logic            shutdown_request_n
);

	// ----------------------------------------
	// State and timers
	// ----------------------------------------
	bfsl_pkg::bfsl_state_t state;
	bfsl_pkg::bfsl_state_t next_state;
	logic                  supply_ok;
	logic                  settle_done;
	logic                  clear_done;
	logic                  hold_done;

	// Indicator low means the driver sees supply undervoltage
	assign supply_ok = ctrl_supply_ok && fault_indicator_n;

	bfsl_timer #(.LIMIT(bfsl_pkg::SETTLE_CYC)) u_settle (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.en      (state == bfsl_pkg::ST_WAIT_SUPPLY && supply_ok),
		.done    (settle_done)
	);

	bfsl_timer #(.LIMIT(bfsl_pkg::CLEAR_CYC)) u_clear (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.en      (state == bfsl_pkg::ST_CLEAR),
		.done    (clear_done)
	);

	bfsl_timer #(.LIMIT(bfsl_pkg::SD_HOLD_CYC)) u_hold (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.en      (state == bfsl_pkg::ST_SHUTDOWN),
		.done    (hold_done)
	);

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			bfsl_pkg::ST_WAIT_SUPPLY: begin
				if (settle_done) begin
					next_state = bfsl_pkg::ST_CLEAR;
				end
			end
			bfsl_pkg::ST_CLEAR: begin
				if (!supply_ok) begin
					next_state = bfsl_pkg::ST_WAIT_SUPPLY;
				end else if (shutdown_cmd) begin
					next_state = bfsl_pkg::ST_SHUTDOWN;
				end else if (clear_done) begin
					next_state = bfsl_pkg::ST_RUN;
				end
			end
			bfsl_pkg::ST_RUN: begin
				if (!supply_ok) begin
					next_state = bfsl_pkg::ST_WAIT_SUPPLY;
				end else if (shutdown_cmd) begin
					next_state = bfsl_pkg::ST_SHUTDOWN;
				end else if (clear_req) begin
					next_state = bfsl_pkg::ST_CLEAR;
				end
			end
			bfsl_pkg::ST_SHUTDOWN: begin
				if (hold_done && !shutdown_cmd) begin
					next_state = bfsl_pkg::ST_CLEAR;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= bfsl_pkg::ST_WAIT_SUPPLY;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Driver pins
	// ----------------------------------------
	// no activity before settle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_drive <= bfsl_pkg::DRIVE_OFF;
		end else if (state == bfsl_pkg::ST_RUN && next_state == bfsl_pkg::ST_RUN) begin
			phase_drive <= phase_cmd;
		end else begin
			phase_drive <= bfsl_pkg::DRIVE_OFF;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			shutdown_request_n <= bfsl_pkg::SD_IDLE;
		end else if (next_state == bfsl_pkg::ST_SHUTDOWN) begin
			shutdown_request_n <= bfsl_pkg::SD_ACTIVE;
		end else begin
			shutdown_request_n <= bfsl_pkg::SD_IDLE;
		end
	end

	// ----------------------------------------
	// User status
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			drive_active <= 1'h0;
			fault_seen   <= 1'h0;
		end else begin
			drive_active <= (next_state == bfsl_pkg::ST_RUN);
			fault_seen   <= !fault_indicator_n;
		end
	end

	// ----------------------------------------
	// Check helpers
	// ----------------------------------------
	// Saturating run lengths; plain delays cannot span hundreds of cycles
	localparam int unsigned OK_SAT   = bfsl_pkg::CLEAR_CYC;
	localparam int unsigned HOLD_SAT = bfsl_pkg::SD_HOLD_CYC;
	logic [bfsl_pkg::TIMER_W-1:0] ok_run;
	logic [bfsl_pkg::TIMER_W-1:0] sd_low_run;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ok_run <= '0;
		end else if (!supply_ok) begin
			ok_run <= '0;
		end else if (ok_run != OK_SAT[bfsl_pkg::TIMER_W-1:0]) begin
			ok_run <= ok_run + 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sd_low_run <= '0;
		end else if (shutdown_request_n) begin
			sd_low_run <= '0;
		end else if (sd_low_run != HOLD_SAT[bfsl_pkg::TIMER_W-1:0]) begin
			sd_low_run <= sd_low_run + 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// release only with drive low
	sd_release_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(shutdown_request_n) |-> (phase_drive == 6'h00) ##1 (phase_drive == 6'h00))
		else $error("shutdown released while phase drive active");

	clear_all_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state == bfsl_pkg::ST_CLEAR && $past(state) != bfsl_pkg::ST_CLEAR)
		|-> (phase_drive == 6'h00) [*8])
		else $error("clear window not all low");

	supply_loss_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!supply_ok && state == bfsl_pkg::ST_RUN) |=> (phase_drive == 6'h00))
		else $error("drive active without stable supply");

	supply_settle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(supply_ok) |-> (phase_drive == 6'h00) [*8])
		else $error("drive applied before supply settled");

	sd_hold_min_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$fell(shutdown_request_n) |-> !shutdown_request_n [*8])
		else $error("shutdown pulse too short");

	sd_response_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(shutdown_cmd && state == bfsl_pkg::ST_RUN && supply_ok) |=> !shutdown_request_n)
		else $error("shutdown command not forwarded");

	supply_stable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(phase_drive != bfsl_pkg::DRIVE_OFF) |-> (ok_run == OK_SAT[bfsl_pkg::TIMER_W-1:0]))
		else $error("phase drive without settled supply");

	sd_hold_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(shutdown_request_n) |-> (sd_low_run == HOLD_SAT[bfsl_pkg::TIMER_W-1:0]))
		else $error("shutdown released before hold time");

	drive_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(phase_drive != bfsl_pkg::DRIVE_OFF) |-> drive_active)
		else $error("phase drive while not active");

endmodule
`default_nettype wire

/* logic/bfsl_pkg.sv */
// Constants and types shared by the bridge shutdown host controller.
// Assumes a single 250 MHz clock and a driver whose pins are synchronous to it.
`default_nettype none
package bfsl_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ     = 250;
	localparam int unsigned SETTLE_NS   = 10000;
	localparam int unsigned CLEAR_NS    = 1000;
	localparam int unsigned SD_HOLD_NS  = 2000;
	// Least times, rounded up to whole cycles
	localparam int unsigned SETTLE_CYC  = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CLEAR_CYC   = (CLEAR_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SD_HOLD_CYC = (SD_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned TIMER_W     = 12;

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	localparam int unsigned PHASES      = 6;
	localparam logic [5:0]  DRIVE_OFF   = 6'h00;
	localparam logic        SD_IDLE     = 1'h1;
	localparam logic        SD_ACTIVE   = 1'h0;

	typedef enum logic [1:0] {
		ST_WAIT_SUPPLY,
		ST_CLEAR,
		ST_RUN,
		ST_SHUTDOWN
	} bfsl_state_t;

endpackage
`default_nettype wire

/* logic/bfsl_timer.sv */
// Saturating up-counter with a level done flag.
// Assumes en is held for the whole interval; dropping en restarts it.
`timescale 1ns/10ps
`default_nettype none
module bfsl_timer #(
	parameter int unsigned LIMIT = 1
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Control
	input  wire logic en,
	output logic      done
);

	logic [bfsl_pkg::TIMER_W-1:0] cnt;

	assign done = en && (cnt == LIMIT[bfsl_pkg::TIMER_W-1:0]);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (!en) begin
			cnt <= '0;
		end else if (cnt != LIMIT[bfsl_pkg::TIMER_W-1:0]) begin
			cnt <= cnt + 1'b1;
		end
	end

endmodule
`default_nettype wire

/* tb/bfsl_drv_model.sv */
// Behavioural bridge driver with its protection paths.
// Assumes pins settle between host clock edges.
`timescale 1ns/10ps
`default_nettype none
module bfsl_drv_model (
	// Drive pins
	input  wire logic [5:0] phase_in,
	input  wire logic       shutdown_n,
	// Fault conditions, bits 5:3 high side
	input  wire logic       ctrl_uv,
	input  wire logic [2:0] boot_uv,
	input  wire logic       over_current,
	input  wire logic       over_temp,
	// Outputs
	output logic [5:0]      switch_on,
	output logic            fault_indicator_n
);
	// Trip and release stamps keep one writer per variable
	time  oc_set_t = 0;
	time  oc_clr_t = 0;
	time  sd_set_t = 0;
	time  sd_clr_t = 0;
	logic oc_latch;
	logic sd_latch;
	always @(posedge over_current) #3000 oc_set_t = $time;
	// delayed shutdown, needs a driven low
	always @(negedge shutdown_n) #2000 if (shutdown_n === 1'h0) sd_set_t = $time;
	always @(phase_in or shutdown_n) begin
		if (phase_in == 6'h00) oc_clr_t = $time;
		if (phase_in == 6'h00 && shutdown_n) sd_clr_t = $time;
	end
	assign oc_latch = (oc_set_t > oc_clr_t);
	assign sd_latch = (sd_set_t > sd_clr_t);
	assign fault_indicator_n = !ctrl_uv;
	assign switch_on = phase_in & ~{boot_uv, 3'h0} &
		{6{!(ctrl_uv || over_temp || oc_latch || sd_latch)}};
endmodule
`default_nettype wire

/* tb/test_bfsl_host.sv */
// Self-checking bench for the bridge shutdown host.
// Assumes package timing constants as delivered.
`timescale 1ns/10ps
`default_nettype none
module test_bfsl_host;
	logic       sys_clk = 1'h0;
	logic       rst_n = 1'h0;
	logic [5:0] phase_cmd = 6'h00;
	logic       shutdown_cmd = 1'h0;
	logic       clear_req = 1'h0;
	logic       ctrl_supply_ok = 1'h1;
	logic       ctrl_uv = 1'h0;
	logic [2:0] boot_uv = 3'h0;
	logic       over_current = 1'h0;
	logic       over_temp = 1'h0;
	wire logic  drive_active, fault_seen, fault_indicator_n, shutdown_request_n;
	wire logic [5:0] phase_drive, switch_on;
	int         n_mismatch = 0;
	int         checks_done = 0;
	always #2 sys_clk = ~sys_clk;
	bfsl_host dut (.sys_clk(sys_clk), .rst_n(rst_n), .phase_cmd(phase_cmd),
		.shutdown_cmd(shutdown_cmd), .clear_req(clear_req), .ctrl_supply_ok(ctrl_supply_ok),
		.drive_active(drive_active), .fault_seen(fault_seen),
		.fault_indicator_n(fault_indicator_n), .phase_drive(phase_drive),
		.shutdown_request_n(shutdown_request_n));
	bfsl_drv_model drv (.phase_in(phase_drive), .shutdown_n(shutdown_request_n),
		.ctrl_uv(ctrl_uv), .boot_uv(boot_uv), .over_current(over_current),
		.over_temp(over_temp), .switch_on(switch_on), .fault_indicator_n(fault_indicator_n));
	task automatic check(input logic [5:0] seen, input logic [5:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Bounded; the watchdog covers a hang
	task automatic wait_run();
		for (int i = 0; i < 4000 && drive_active !== 1'h1; i++) cyc(1);
		cyc(3);
	endtask
	task automatic test_follow();
		wait_run();
		@(posedge sys_clk) phase_cmd <= 6'h2A;
		cyc(3);
		check(switch_on, 6'h2A);
		check(phase_drive, 6'h2A);
		check({5'h00, drive_active}, 6'h01);
		@(posedge sys_clk) boot_uv <= 3'h4;
		cyc(1);
		check(switch_on, 6'h0A);
		@(posedge sys_clk) boot_uv <= 3'h0;
		cyc(1);
		check(switch_on, 6'h2A);
		@(posedge sys_clk) over_temp <= 1'h1;
		cyc(1);
		check(switch_on, 6'h00);
		@(posedge sys_clk) over_temp <= 1'h0;
		cyc(1);
		check(switch_on, 6'h2A);
	endtask
	task automatic test_shutdown();
		@(posedge sys_clk) shutdown_cmd <= 1'h1;
		cyc(2);
		check({5'h00, shutdown_request_n}, 6'h00);
		check(phase_drive, 6'h00);
		check({5'h00, drive_active}, 6'h00);
		cyc(600);
		check({5'h00, shutdown_request_n}, 6'h00);
		@(posedge sys_clk) shutdown_cmd <= 1'h0;
		wait_run();
		check(switch_on, 6'h2A);
	endtask
	task automatic test_overcurrent();
		@(posedge sys_clk) over_current <= 1'h1;
		cyc(700);
		check(switch_on, 6'h2A);
		cyc(100);
		@(posedge sys_clk) over_current <= 1'h0;
		cyc(2);
		check(switch_on, 6'h00);
		@(posedge sys_clk) clear_req <= 1'h1;
		@(posedge sys_clk) clear_req <= 1'h0;
		cyc(3);
		wait_run();
		check(switch_on, 6'h2A);
	endtask
	task automatic test_undervoltage();
		@(posedge sys_clk) ctrl_uv <= 1'h1;
		cyc(3);
		check({5'h00, fault_seen}, 6'h01);
		check(switch_on, 6'h00);
		check(phase_drive, 6'h00);
		@(posedge sys_clk) ctrl_uv <= 1'h0;
		cyc(3);
		check({5'h00, fault_seen}, 6'h00);
		wait_run();
		check(switch_on, 6'h2A);
	endtask
	task automatic test_supply_flag();
		@(posedge sys_clk) ctrl_supply_ok <= 1'h0;
		cyc(2);
		check(phase_drive, 6'h00);
		check({5'h00, drive_active}, 6'h00);
		@(posedge sys_clk) ctrl_supply_ok <= 1'h1;
		cyc(100);
		check(phase_drive, 6'h00);
		wait_run();
		check(phase_drive, 6'h2A);
	endtask
	task automatic test_reset();
		@(posedge sys_clk) rst_n <= 1'h0;
		cyc(1);
		check(phase_drive, 6'h00);
		check({5'h00, shutdown_request_n}, 6'h01);
		@(posedge sys_clk) rst_n <= 1'h1;
		cyc(2);
		check({5'h00, drive_active}, 6'h00);
		check(phase_drive, 6'h00);
	endtask
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'h1;
		cyc(1);
		check({5'h00, shutdown_request_n}, 6'h01);
		test_follow();
		test_shutdown();
		test_overcurrent();
		test_undervoltage();
		test_supply_flag();
		test_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
